// ==== logic/hw_config_memory_readout.sv ====
`timescale 1ns/1ps
`include "hwcfg_cfg.svh"

module hw_config_memory_readout
    import hwcfg_pkg::*;
#(
    parameter logic [7:0] FLASH_KB = `FLASH_KB_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_prog_mode,
    input wire logic i_prog_we,
    input wire logic [15:0] i_prog_addr,
    input wire logic [7:0] i_prog_wdata,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic o_sfr_hit,
    output logic o_sfr_rvalid,
    output logic [7:0] o_sfr_rdata,
    input wire logic i_wdt_expire,
    output logic o_wdt_irq,
    output logic o_wdt_reset_req,
    input wire logic i_fw_flash_wr,
    input wire logic [15:0] i_fw_flash_addr,
    output logic o_fw_flash_wr_ok,
    output logic o_program_access_enable,
    output logic o_boot_rom_enable,
    output logic [7:0] o_data_flash_kb,
    output logic [7:0] o_prog_flash_kb,
    output logic [1:0] o_digital_brownout_level,
    output logic [1:0] o_analog_brownout_level,
    output logic o_digital_brownout_enable,
    output logic o_analog_brownout_enable,
    output logic o_port0_gpio,
    output logic o_port23_gpio,
    output logic o_ext_strobes_on_p3,
    output logic o_cpu_run
);
    // Programming pins cross into the core clock
    prog_bus_t sync1;
    prog_bus_t sync2;
    logic we_prev;
    prog_bus_t prog_pins;

    assign prog_pins = '{mode: i_prog_mode, we: i_prog_we, addr: i_prog_addr, wdata: i_prog_wdata};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
            we_prev <= 1'b0;
        end else begin
            sync1 <= prog_pins;
            sync2 <= sync1;
            we_prev <= sync2.we;
        end
    end

    // Store write path; address and data held stable by host around the strobe
    logic store_we;
    logic in_window;
    assign in_window = (sync2.addr >= `CFG_PROG_BASE) && (sync2.addr <= `CFG_PROG_TOP);
    assign store_we = sync2.mode && sync2.we && !we_prev && in_window;

    logic [`CFG_AW-1:0] cfg_addr;
    logic [`CFG_AW-1:0] mem_raddr;
    logic [7:0] mem_rdata;
    load_state_t state;
    load_state_t next_state;

    always_comb begin
        case (state)
            LOAD_SUPPLY: mem_raddr = `CFG_SUPPLY_OFS;
            LOAD_SECURITY: mem_raddr = `CFG_SECURITY_OFS;
            default: mem_raddr = cfg_addr;
        endcase
    end

    config_store_mem #(
        .DEPTH(`CFG_DEPTH),
        .WIDTH(8),
        .AW(`CFG_AW)
    ) u_store (
        .i_clk(i_clk),
        .i_we(store_we),
        .i_waddr(sync2.addr[`CFG_AW-1:0]),
        .i_wdata(sync2.wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    // Load sequencer: CPU held until both bytes are latched
    flash_security_t security;
    flash_security_t next_security;
    supply_port_t supply;
    supply_port_t next_supply;

    always_comb begin
        next_state = state;
        next_security = security;
        next_supply = supply;
        case (state)
            LOAD_SUPPLY: begin
                next_supply = supply_port_t'(mem_rdata);
                next_state = LOAD_SECURITY;
            end
            LOAD_SECURITY: begin
                next_security = flash_security_t'(mem_rdata);
                next_state = RUN;
            end
            RUN: begin
                if (sync2.mode) begin
                    next_state = PROG_HOLD;
                end
            end
            PROG_HOLD: begin
                // Reload after programming so new bytes take effect
                if (!sync2.mode) begin
                    next_state = LOAD_SUPPLY;
                end
            end
            default: next_state = LOAD_SUPPLY;
        endcase
        if (sync2.mode && state != PROG_HOLD) begin
            next_state = PROG_HOLD;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= LOAD_SUPPLY;
            security <= flash_security_t'(`SECURITY_RESET);
            supply <= supply_port_t'(`SUPPLY_RESET);
        end else begin
            state <= next_state;
            security <= next_security;
            supply <= next_supply;
        end
    end

    assign o_cpu_run = (state == RUN);

    // Special function register slave
    logic next_rvalid;
    logic [7:0] next_rdata;
    logic [`CFG_AW-1:0] next_cfg_addr;

    assign o_sfr_hit = (i_sfr_addr == `SFR_ADDR_REG) || (i_sfr_addr == `SFR_DATA_REG);

    always_comb begin
        next_cfg_addr = cfg_addr;
        next_rvalid = 1'b0;
        next_rdata = o_sfr_rdata;
        // Only the address register is writable; data register ignores writes
        if (i_sfr_wr && i_sfr_addr == `SFR_ADDR_REG) begin
            next_cfg_addr = i_sfr_wdata[`CFG_AW-1:0];
        end
        if (i_sfr_rd && o_sfr_hit) begin
            next_rvalid = 1'b1;
            if (i_sfr_addr == `SFR_ADDR_REG) begin
                next_rdata = {1'b0, cfg_addr};
            end else begin
                next_rdata = mem_rdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_addr <= '0;
            o_sfr_rvalid <= 1'b0;
            o_sfr_rdata <= '0;
        end else begin
            cfg_addr <= next_cfg_addr;
            o_sfr_rvalid <= next_rvalid;
            o_sfr_rdata <= next_rdata;
        end
    end

    // Watchdog action routing
    logic next_wdt_irq;
    logic next_wdt_rst;

    always_comb begin
        next_wdt_irq = i_wdt_expire && o_cpu_run && !security.watchdog_reset_select;
        next_wdt_rst = i_wdt_expire && o_cpu_run && security.watchdog_reset_select;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wdt_irq <= 1'b0;
            o_wdt_reset_req <= 1'b0;
        end else begin
            o_wdt_irq <= next_wdt_irq;
            o_wdt_reset_req <= next_wdt_rst;
        end
    end

    // Flash partition decode
    function automatic logic [7:0] data_kb(input logic [2:0] sel);
        case (sel)
            3'h1: data_kb = 8'h20;
            3'h2: data_kb = 8'h10;
            3'h3: data_kb = 8'h08;
            3'h4: data_kb = 8'h04;
            3'h5: data_kb = 8'h02;
            3'h6: data_kb = 8'h01;
            default: data_kb = 8'h00;
        endcase
    endfunction

    logic [7:0] sel_kb;
    logic [2:0] dsel;
    assign dsel = {security.data_flash_size_b2, security.data_flash_size_b1, security.data_flash_size_b0};
    assign sel_kb = data_kb(dsel);
    assign o_data_flash_kb = (sel_kb > FLASH_KB) ? FLASH_KB : sel_kb;
    assign o_prog_flash_kb = FLASH_KB - o_data_flash_kb;

    // Firmware program-flash write gate; address is offset within program flash
    logic in_reset_sector;
    logic in_prog_region;
    assign in_reset_sector = ({2'h0, i_fw_flash_addr[15:10]} < `RESET_SECTOR_KB);
    assign in_prog_region = ({2'h0, i_fw_flash_addr[15:10]} < o_prog_flash_kb);
    // A 4k program area lies wholly in the reset sector, so the sector lock covers it
    assign o_fw_flash_wr_ok = i_fw_flash_wr && o_cpu_run && in_prog_region
        && !security.program_flash_lock
        && !(security.reset_sector_lock && in_reset_sector);

    assign o_program_access_enable = security.program_access_enable;
    assign o_boot_rom_enable = security.boot_rom_enable;
    assign o_digital_brownout_level = {supply.digital_brownout_level_b1,
        supply.digital_brownout_level_b0};
    assign o_analog_brownout_level = {supply.analog_brownout_level_b1,
        supply.analog_brownout_level_b0};
    assign o_analog_brownout_enable = !supply.analog_brownout_disable;
    assign o_digital_brownout_enable = !supply.digital_brownout_disable;
    assign o_port0_gpio = supply.port0_gpio_select;
    assign o_port23_gpio = supply.port23_gpio_select;
    assign o_ext_strobes_on_p3 = !(supply.port0_gpio_select && supply.port23_gpio_select);

    property p_no_run_write;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_cpu_run || !sync2.mode) |-> !store_we;
    endproperty
    a_no_run_write: assert property (p_no_run_write) else $error("store written outside programming");

    property p_load_seq;
        @(posedge i_clk) disable iff (!i_reset_n)
        (state == LOAD_SUPPLY && !sync2.mode) |=> (state == LOAD_SECURITY) ##1 (o_cpu_run || $past(sync2.mode));
    endproperty
    a_load_seq: assert property (p_load_seq) else $error("config load sequence broken");

    property p_data_reg_read;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_sfr_rd && i_sfr_addr == `SFR_DATA_REG && o_cpu_run) |=> o_sfr_rvalid && o_sfr_rdata == $past(mem_rdata);
    endproperty
    a_data_reg_read: assert property (p_data_reg_read) else $error("data register wrong byte");

    property p_addr_reg_range;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_sfr_wr && i_sfr_addr == `SFR_ADDR_REG) |=> cfg_addr == $past(i_sfr_wdata[6:0]);
    endproperty
    a_addr_reg_range: assert property (p_addr_reg_range) else $error("address register not loaded");

    property p_wdt_irq;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_wdt_expire && o_cpu_run && !security.watchdog_reset_select) |=> o_wdt_irq && !o_wdt_reset_req;
    endproperty
    a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog interrupt missing");

    property p_wdt_rst;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_wdt_expire && o_cpu_run && security.watchdog_reset_select) |=> o_wdt_reset_req && !o_wdt_irq;
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset missing");

    property p_prog_lock;
        @(posedge i_clk) disable iff (!i_reset_n)
        security.program_flash_lock |-> !o_fw_flash_wr_ok;
    endproperty
    a_prog_lock: assert property (p_prog_lock) else $error("locked program flash written");

    property p_sector_lock;
        @(posedge i_clk) disable iff (!i_reset_n)
        (security.reset_sector_lock && i_fw_flash_addr[15:12] == 4'h0) |-> !o_fw_flash_wr_ok;
    endproperty
    a_sector_lock: assert property (p_sector_lock) else $error("reset sector written");

    property p_clamp;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_data_flash_kb <= FLASH_KB) && (o_prog_flash_kb + o_data_flash_kb == FLASH_KB);
    endproperty
    a_clamp: assert property (p_clamp) else $error("flash partition exceeds part");
endmodule : hw_config_memory_readout

// ==== logic/hwcfg_cfg.svh ====
`ifndef HWCFG_CFG_SVH
`define HWCFG_CFG_SVH

`define CFG_DEPTH 128
`define CFG_AW 7
`define CFG_PROG_BASE 16'h8000
`define CFG_PROG_TOP 16'h807f
`define CFG_SUPPLY_OFS 7'h7e
`define CFG_SECURITY_OFS 7'h7f
`define SFR_ADDR_REG 8'h93
`define SFR_DATA_REG 8'h94
`define SUPPLY_RESET 8'hff
`define SECURITY_RESET 8'hff
`define FLASH_KB_DEFAULT 8'h20
`define RESET_SECTOR_KB 8'h04
`define SYNC_W 26

`endif

// ==== logic/hwcfg_pkg.sv ====
package hwcfg_pkg;

    typedef struct packed {
        logic program_access_enable;
        logic program_flash_lock;
        logic reset_sector_lock;
        logic boot_rom_enable;
        logic watchdog_reset_select;
        logic data_flash_size_b2;
        logic data_flash_size_b1;
        logic data_flash_size_b0;
    } flash_security_t;

    typedef struct packed {
        logic digital_brownout_level_b1;
        logic digital_brownout_level_b0;
        logic analog_brownout_level_b1;
        logic analog_brownout_level_b0;
        logic analog_brownout_disable;
        logic digital_brownout_disable;
        logic port0_gpio_select;
        logic port23_gpio_select;
    } supply_port_t;

    typedef struct packed {
        logic mode;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } prog_bus_t;

    typedef enum logic [1:0] {
        LOAD_SUPPLY = 2'b00,
        LOAD_SECURITY = 2'b01,
        RUN = 2'b10,
        PROG_HOLD = 2'b11
    } load_state_t;

endpackage : hwcfg_pkg

// ==== logic/config_store_mem.sv ====
`timescale 1ns/1ps
module config_store_mem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8,
    parameter int AW = 7
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    // Nonvolatile image: no reset, contents survive system reset
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule : config_store_mem

// ==== test/prog_host.sv ====
`timescale 1ns/1ps
module prog_host
    import hwcfg_pkg::*;
(
    input wire logic i_clk,
    output prog_bus_t o_bus
);
    initial begin
        o_bus = '0;
    end

    // Address and data settle a cycle ahead of the strobe and outlast it
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_bus.addr = a;
        o_bus.wdata = d;
        @(negedge i_clk);
        o_bus.we = 1'b1;
        repeat (4) @(negedge i_clk);
        o_bus.we = 1'b0;
        repeat (4) @(negedge i_clk);
        // Released lines show the inverse, never a held value
        o_bus.addr = ~a;
        o_bus.wdata = ~d;
    endtask : put

    task automatic enter();
        @(negedge i_clk);
        o_bus.mode = 1'b1;
        repeat (5) @(negedge i_clk);
    endtask : enter

    task automatic leave();
        @(negedge i_clk);
        o_bus.mode = 1'b0;
    endtask : leave

    task automatic cfg(input logic [7:0] sup, input logic [7:0] sec);
        put(16'h807e, sup);
        put(16'h807f, sec);
    endtask : cfg

    task automatic load(input logic [7:0] img [128]);
        for (int i = 2; i < 8'h70; i++) begin
            put(16'h8000 + 16'(i), img[i]);
        end
        cfg(img[8'h7e], img[8'h7f]);
    endtask : load
endmodule : prog_host

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
    import hwcfg_pkg::*;
    localparam logic [7:0] FKB = 8'h10;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    prog_bus_t pbus;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic wdt = 1'b0;
    logic fw_wr = 1'b0;
    logic [15:0] fw_addr = 16'h0000;
    logic hit, rvalid, irq, wrst, wok, pae, boot, den, aen, p0, p23, strb, run;
    logic [7:0] rd_data, dkb, pkb;
    logic [1:0] dbl, abl;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'h36d19dbd;
    logic [7:0] img [128];
    logic [7:0] sec, sup, d, t;
    logic v;

    prog_host host (.i_clk(i_clk), .o_bus(pbus));
    hw_config_memory_readout #(.FLASH_KB(FKB)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_prog_mode(pbus.mode), .i_prog_we(pbus.we), .i_prog_addr(pbus.addr), .i_prog_wdata(pbus.wdata),
        .i_sfr_addr(sfr_addr), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata),
        .o_sfr_hit(hit), .o_sfr_rvalid(rvalid), .o_sfr_rdata(rd_data), .i_wdt_expire(wdt),
        .o_wdt_irq(irq), .o_wdt_reset_req(wrst), .i_fw_flash_wr(fw_wr), .i_fw_flash_addr(fw_addr),
        .o_fw_flash_wr_ok(wok), .o_program_access_enable(pae), .o_boot_rom_enable(boot),
        .o_data_flash_kb(dkb), .o_prog_flash_kb(pkb), .o_digital_brownout_level(dbl),
        .o_analog_brownout_level(abl), .o_digital_brownout_enable(den), .o_analog_brownout_enable(aen),
        .o_port0_gpio(p0), .o_port23_gpio(p23), .o_ext_strobes_on_p3(strb), .o_cpu_run(run));

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h00000000);
        return lfsr[7:0];
    endfunction : rnd

    function automatic logic [7:0] exp_dkb(input logic [7:0] s);
        logic [7:0] k;
        k = (s[2:0] == 3'b000 || s[2:0] == 3'b111) ? 8'h00 : 8'h40 >> s[2:0];
        return (k > FKB) ? FKB : k;
    endfunction : exp_dkb

    // Callers sit at a falling edge; a write may be followed at once by a read
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] wd);
        sfr_addr = a;
        sfr_wdata = wd;
        sfr_wr = 1'b1;
        @(negedge i_clk);
        sfr_wr = 1'b0;
    endtask : sfr_w

    task automatic sfr_r(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'b1;
        #1;
        `CHK("hit", (a == 8'h93 || a == 8'h94), hit)
        @(negedge i_clk);
        sfr_rd = 1'b0;
        d = rd_data;
        v = rvalid;
        @(negedge i_clk);
    endtask : sfr_r

    task automatic read_byte(input logic [7:0] a);
        sfr_w(8'h93, a);
        sfr_r(8'h94);
        `CHK("rvalid", 1'b1, v)
        `CHK("cfg_byte", img[a], d)
    endtask : read_byte

    task automatic wait_run();
        int n;
        n = 0;
        while (run !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        `CHK("cpu_run", 1'b1, run)
    endtask : wait_run

    task automatic check_cfg();
        logic e;
        `CHK("access", sec[7], pae)
        `CHK("boot_rom", sec[4], boot)
        `CHK("data_kb", exp_dkb(sec), dkb)
        `CHK("prog_kb", FKB - exp_dkb(sec), pkb)
        `CHK("dig_level", sup[7:6], dbl)
        `CHK("ana_level", sup[5:4], abl)
        `CHK("ana_en", ~sup[3], aen)
        `CHK("dig_en", ~sup[2], den)
        `CHK("p0_gpio", sup[1], p0)
        `CHK("p23_gpio", sup[0], p23)
        `CHK("strobes", ~(sup[1] & sup[0]), strb)
        wdt = 1'b1;
        @(negedge i_clk);
        wdt = 1'b0;
        `CHK("wdt_irq", ~sec[3], irq)
        `CHK("wdt_rst", sec[3], wrst)
        for (int k = 0; k < 4; k++) begin
            t = rnd();
            fw_addr = (k == 0) ? 16'h0fff : (k == 1) ? 16'h1000 : {2'b00, t[5:0], rnd()};
            fw_wr = 1'b1;
            #1;
            e = ~sec[6] & ~(sec[5] & (fw_addr < 16'h1000)) & ({2'b00, fw_addr[15:10]} < FKB - exp_dkb(sec));
            `CHK("fw_wr_ok", e, wok)
            @(negedge i_clk);
        end
        fw_wr = 1'b0;
    endtask : check_cfg

    task automatic stop_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (2) @(negedge i_clk);
        `CHK("prog_kb_rst", FKB, pkb)
        `CHK("run_rst", 1'b0, run)
        i_reset_n = 1'b1;
        @(negedge i_clk);
        sfr_r(8'h93);
        `CHK("addr_reg_rst", 8'h00, d)
        for (int i = 0; i < 128; i++) begin
            img[i] = rnd();
        end
        host.enter();
        `CHK("run_prog", 1'b0, run)
        wdt = 1'b1;
        @(negedge i_clk);
        wdt = 1'b0;
        `CHK("wdt_idle", 2'b00, {irq, wrst})
        host.load(img);
        host.leave();
        wait_run();
        for (int a = 2; a < 8'h70; a++) begin
            read_byte(8'(a));
        end
        read_byte(8'h7e);
        read_byte(8'h7f);
        // Firmware write, host write outside mode and outside window all miss the store
        sfr_w(8'h94, ~img[5]);
        host.put(16'h8005, ~img[5]);
        host.enter();
        host.put(16'h9005, ~img[5]);
        host.leave();
        wait_run();
        read_byte(8'h05);
        sfr_w(8'h93, 8'h85);
        sfr_r(8'h93);
        `CHK("addr_reg_rd", 8'h05, d)
        sfr_r(8'h95);
        `CHK("unmapped", 1'b0, v)
        for (int i = 0; i < 8; i++) begin
            t = rnd();
            sec = {t[7:3], 3'(i)};
            sup = rnd();
            // Both watchdog actions and every port mode are reached
            sup[1:0] = i[1:0];
            sec[3] = i[0];
            if (i == 3) begin
                sec[6:5] = 2'b01;
            end
            if (i == 4) begin
                sec[6:5] = 2'b00;
            end
            host.enter();
            host.cfg(sup, sec);
            host.leave();
            wait_run();
            check_cfg();
        end
        img[8'h7e] = sup;
        img[8'h7f] = sec;
        read_byte(8'h7f);
        i_reset_n = 1'b0;
        @(negedge i_clk);
        i_reset_n = 1'b1;
        wait_run();
        check_cfg();
        stop_test();
    end
endmodule : tb_top
